// ==== dispatch_completion_control.sv ====
// Behaviour
// - fetch up to four instructions per cycle
// - queue holds twelve, refuses fetch when full
// - dispatch only from the three bottom slots
// - at most three dispatched per cycle
// - float one, vector two, general three
// - dispatch needs a free retire queue entry
// - retire when older done, finished, no exception
// - track all dispatched, retire in order
// - mispredict discards all younger instructions
// - retire at most three per cycle
// - at most sixteen in flight
// - at most three unresolved branches outstanding
// - 2048 two-bit saturating history entries
// - 128-entry four-way target cache, early supply
// - eight-entry return stack predicts link returns
// - sixteen renames per class, stall when exhausted
// - branches touching neither count nor link folded
module dispatch_completion_control #(
   parameter int IQ_DEPTH = dcc_pkg::IQ_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic [dcc_pkg::FETCH_W-1:0] fetch_valid_i,
   input wire dcc_pkg::insn_s [dcc_pkg::FETCH_W-1:0] fetch_insn_i,
   input wire logic [1:0] gen_room_i,
   input wire logic flt_room_i,
   input wire logic [1:0] vec_room_i,
   input wire logic fin_valid_i,
   input wire logic [dcc_pkg::TAG_W-1:0] fin_tag_i,
   input wire logic fin_exc_i,
   input wire logic res_valid_i,
   input wire logic [dcc_pkg::TAG_W-1:0] res_tag_i,
   input wire logic res_mispredict_i,
   input wire logic [31:0] res_pc_i,
   input wire logic res_taken_i,
   input wire logic look_valid_i,
   input wire logic [31:0] look_pc_i,
   input wire logic btc_fill_valid_i,
   input wire logic [31:0] btc_fill_pc_i,
   input wire logic [31:0] btc_fill_target_i,
   input wire logic [dcc_pkg::BTC_WORDS-1:0][31:0] btc_fill_words_i,
   output logic fetch_ready_o,
   output logic [dcc_pkg::DISP_W-1:0] disp_valid_o,
   output dcc_pkg::insn_s [dcc_pkg::DISP_W-1:0] disp_insn_o,
   output logic [dcc_pkg::DISP_W-1:0][dcc_pkg::TAG_W-1:0] disp_tag_o,
   output logic [dcc_pkg::RET_W-1:0] retire_valid_o,
   output logic [dcc_pkg::RET_W-1:0][31:0] retire_pc_o,
   output logic exc_valid_o,
   output logic [31:0] exc_pc_o,
   output logic flush_o,
   output logic [4:0] inflight_o,
   output logic pred_taken_o,
   output logic btc_hit_o,
   output logic [31:0] btc_target_o,
   output logic [dcc_pkg::BTC_WORDS-1:0][31:0] btc_words_o,
   output logic [31:0] ras_top_o,
   output logic ras_valid_o
);
   if (IQ_DEPTH < dcc_pkg::FETCH_W + dcc_pkg::DISP_W || IQ_DEPTH > 15) begin : g_chk
      $error("Instruction queue depth out of range");
   end
   function automatic logic [4:0] cnt16(input logic [15:0] v);
      logic [4:0] c;
      c = '0;
      for (int i = 0; i < 16; i++) begin
         c = c + 5'(v[i]);
      end
      return c;
   endfunction
   dcc_pkg::insn_s instruction_queue_q [IQ_DEPTH], iq_d [IQ_DEPTH];
   logic [3:0] iq_cnt_q, iq_cnt_d;
   dcc_pkg::cq_s retire_queue_q [dcc_pkg::CQ_DEPTH];
   logic [15:0] cqv_q, unres_v, rg_v, rf_v, rv_v, kill_v;
   logic [dcc_pkg::TAG_W-1:0] head_q, tail;
   logic [4:0] cq_cnt, unres_cnt, rn_gen, rn_flt, rn_vec;
   logic [1:0] n_disp, n_ret;
   logic exc_take, mis_take, kill_all, push, pop;
   logic [31:0] push_addr;
   always_comb begin
      for (int i = 0; i < dcc_pkg::CQ_DEPTH; i++) begin
         unres_v[i] = cqv_q[i] && retire_queue_q[i].unres;
         rg_v[i] = cqv_q[i] && retire_queue_q[i].rn == dcc_pkg::U_GEN;
         rf_v[i] = cqv_q[i] && retire_queue_q[i].rn == dcc_pkg::U_FLT;
         rv_v[i] = cqv_q[i] && retire_queue_q[i].rn == dcc_pkg::U_VEC;
      end
   end
   assign cq_cnt = cnt16(cqv_q);
   assign tail = head_q + cq_cnt[3:0];
   assign unres_cnt = cnt16(unres_v);
   assign rn_gen = cnt16(rg_v);
   assign rn_flt = cnt16(rf_v);
   assign rn_vec = cnt16(rv_v);
   always_comb begin
      logic go;
      logic [dcc_pkg::TAG_W-1:0] idx;
      go = 1'b1;
      idx = '0;
      n_ret = 2'h0;
      exc_take = 1'b0;
      for (int k = 0; k < dcc_pkg::RET_W; k++) begin
         idx = head_q + 4'(k);
         if (go && cqv_q[idx] && retire_queue_q[idx].fin) begin
            if (retire_queue_q[idx].exc) begin
               exc_take = 1'b1;
               go = 1'b0;
            end else begin
               n_ret = n_ret + 2'h1;
            end
         end else begin
            go = 1'b0;
         end
      end
   end
   // kill everything younger than the branch
   assign mis_take = res_valid_i && res_mispredict_i && cqv_q[res_tag_i] && !exc_take;
   assign kill_all = exc_take || mis_take;
   always_comb begin
      for (int i = 0; i < dcc_pkg::CQ_DEPTH; i++) begin
         kill_v[i] = exc_take ||
            (mis_take && (4'(i) - head_q) > (res_tag_i - head_q));
      end
   end
   // in-order scan of bottom slots only
   always_comb begin
      logic stop, ok;
      logic [4:0] g, f, v, b, rg, rf, rv;
      dcc_pkg::insn_s s;
      stop = kill_all;
      ok = 1'b0;
      s = '0;
      n_disp = 2'h0;
      g = '0;
      f = '0;
      v = '0;
      b = unres_cnt;
      rg = rn_gen;
      rf = rn_flt;
      rv = rn_vec;
      push = 1'b0;
      pop = 1'b0;
      push_addr = '0;
      for (int k = 0; k < dcc_pkg::DISP_W; k++) begin
         s = instruction_queue_q[k];
         ok = !stop && 4'(k) < iq_cnt_q && cq_cnt + 5'(k) < 5'(dcc_pkg::CQ_DEPTH);
         case (s.iq)
            dcc_pkg::U_GEN: ok = ok && g < 5'(dcc_pkg::GEN_CAP) && g < 5'(gen_room_i);
            dcc_pkg::U_FLT: ok = ok && f < 5'(dcc_pkg::FLT_CAP) && f < 5'(flt_room_i);
            dcc_pkg::U_VEC: ok = ok && v < 5'(dcc_pkg::VEC_CAP) && v < 5'(vec_room_i);
            default: ok = ok;
         endcase
         case (s.rn)
            dcc_pkg::U_GEN: ok = ok && rg < 5'(dcc_pkg::RN_DEPTH);
            dcc_pkg::U_FLT: ok = ok && rf < 5'(dcc_pkg::RN_DEPTH);
            dcc_pkg::U_VEC: ok = ok && rv < 5'(dcc_pkg::RN_DEPTH);
            default: ok = ok;
         endcase
         ok = ok && !(s.is_br && b >= 5'(dcc_pkg::MAX_UNRES));
         if (ok) begin
            n_disp = n_disp + 2'h1;
            g = g + 5'(s.iq == dcc_pkg::U_GEN);
            f = f + 5'(s.iq == dcc_pkg::U_FLT);
            v = v + 5'(s.iq == dcc_pkg::U_VEC);
            b = b + 5'(s.is_br);
            rg = rg + 5'(s.rn == dcc_pkg::U_GEN);
            rf = rf + 5'(s.rn == dcc_pkg::U_FLT);
            rv = rv + 5'(s.rn == dcc_pkg::U_VEC);
            if (s.is_call && !push) begin
               push = 1'b1;
               push_addr = s.pc + dcc_pkg::PC_STEP;
            end
            if (s.is_ret && !push) begin
               pop = 1'b1;
            end
         end else begin
            stop = 1'b1;
         end
      end
   end
   // up to four lanes compacted into the queue
   always_comb begin
      logic [4:0] n;
      n = 5'(iq_cnt_q) - 5'(n_disp);
      for (int i = 0; i < IQ_DEPTH; i++) begin
         iq_d[i] = (i + int'(n_disp) < IQ_DEPTH) ? instruction_queue_q[i + int'(n_disp)] : '0;
      end
      if (kill_all) begin
         n = '0;
      end else if (fetch_ready_o) begin
         for (int k = 0; k < dcc_pkg::FETCH_W; k++) begin
            // fold branches with no count or link update
            if (fetch_valid_i[k] && !(fetch_insn_i[k].is_br && !fetch_insn_i[k].upd_cl)) begin
               iq_d[n[3:0]] = fetch_insn_i[k];
               n = n + 5'h1;
            end
         end
      end
      iq_cnt_d = n[3:0];
   end
   // ready only while a full fetch group fits
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         iq_cnt_q <= '0;
         fetch_ready_o <= 1'b0;
      end else begin
         iq_cnt_q <= iq_cnt_d;
         fetch_ready_o <= iq_cnt_d <= 4'(IQ_DEPTH - dcc_pkg::FETCH_W);
      end
   end
   always_ff @(posedge sys_clk_i) begin
      instruction_queue_q <= iq_d;
   end
   // entries allocated in order at the tail
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cqv_q <= '0;
         head_q <= '0;
      end else begin
         for (int k = 0; k < dcc_pkg::RET_W; k++) begin
            if (2'(k) < n_ret) begin
               cqv_q[head_q + 4'(k)] <= 1'b0;
            end
         end
         // discarded entries and renames freed at once
         for (int i = 0; i < dcc_pkg::CQ_DEPTH; i++) begin
            if (kill_v[i]) begin
               cqv_q[i] <= 1'b0;
            end
         end
         for (int k = 0; k < dcc_pkg::DISP_W; k++) begin
            if (2'(k) < n_disp) begin
               cqv_q[tail + 4'(k)] <= 1'b1;
            end
         end
         head_q <= head_q + 4'(n_ret);
      end
   end
   always_ff @(posedge sys_clk_i) begin
      for (int k = 0; k < dcc_pkg::DISP_W; k++) begin
         if (2'(k) < n_disp) begin
            retire_queue_q[tail + 4'(k)] <= '{pc: instruction_queue_q[k].pc,
               rn: instruction_queue_q[k].rn, fin: 1'b0, exc: 1'b0,
               unres: instruction_queue_q[k].is_br};
         end
      end
      if (fin_valid_i) begin
         retire_queue_q[fin_tag_i].fin <= 1'b1;
         retire_queue_q[fin_tag_i].exc <= fin_exc_i;
      end
      if (res_valid_i) begin
         retire_queue_q[res_tag_i].fin <= 1'b1;
         retire_queue_q[res_tag_i].unres <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         disp_valid_o <= '0;
         disp_insn_o <= '0;
         disp_tag_o <= '0;
      end else begin
         for (int k = 0; k < dcc_pkg::DISP_W; k++) begin
            disp_valid_o[k] <= 2'(k) < n_disp;
            disp_insn_o[k] <= instruction_queue_q[k];
            disp_tag_o[k] <= tail + 4'(k);
         end
      end
   end
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         retire_valid_o <= '0;
         retire_pc_o <= '0;
         exc_valid_o <= 1'b0;
         exc_pc_o <= '0;
         flush_o <= 1'b0;
         inflight_o <= '0;
      end else begin
         for (int k = 0; k < dcc_pkg::RET_W; k++) begin
            retire_valid_o[k] <= 2'(k) < n_ret;
            retire_pc_o[k] <= retire_queue_q[head_q + 4'(k)].pc;
         end
         exc_valid_o <= exc_take;
         exc_pc_o <= retire_queue_q[head_q + 4'(n_ret)].pc;
         flush_o <= kill_all;
         inflight_o <= cq_cnt;
      end
   end
   branch_predict u_pred (
      .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .look_valid_i(look_valid_i),
      .look_pc_i(look_pc_i), .upd_valid_i(res_valid_i), .upd_pc_i(res_pc_i),
      .upd_taken_i(res_taken_i), .fill_valid_i(btc_fill_valid_i), .fill_pc_i(btc_fill_pc_i),
      .fill_target_i(btc_fill_target_i), .fill_words_i(btc_fill_words_i), .push_i(push),
      .push_addr_i(push_addr), .pop_i(pop), .pred_taken_o(pred_taken_o), .btc_hit_o(btc_hit_o),
      .btc_target_o(btc_target_o), .btc_words_o(btc_words_o), .ras_top_o(ras_top_o),
      .ras_valid_o(ras_valid_o)
   );
   logic [1:0] disp_flt;
   assign disp_flt = 2'(disp_valid_o[0] && disp_insn_o[0].iq == dcc_pkg::U_FLT)
      + 2'(disp_valid_o[1] && disp_insn_o[1].iq == dcc_pkg::U_FLT)
      + 2'(disp_valid_o[2] && disp_insn_o[2].iq == dcc_pkg::U_FLT);
   property p_iq_room;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      fetch_ready_o |-> iq_cnt_q <= 4'(IQ_DEPTH - dcc_pkg::FETCH_W);
   endproperty
   a_iq_room: assert property (p_iq_room) else $error("Ready with queue near full");
   property p_bottom;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      ##1 disp_valid_o[2] |-> $past(iq_cnt_q) >= 4'h3;
   endproperty
   a_bottom: assert property (p_bottom) else $error("Dispatched beyond queued slots");
   property p_flt_one;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      disp_flt <= 2'h1;
   endproperty
   a_flt_one: assert property (p_flt_one) else $error("Two float dispatches in a cycle");
   property p_cq_full;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      cq_cnt == 5'(dcc_pkg::CQ_DEPTH) |=> disp_valid_o == '0;
   endproperty
   a_cq_full: assert property (p_cq_full) else $error("Dispatch into full retire queue");
   property p_in_order;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (retire_valid_o[1] |-> retire_valid_o[0]) and (retire_valid_o[2] |-> retire_valid_o[1]);
   endproperty
   a_in_order: assert property (p_in_order) else $error("Retire out of order");
   sequence s_mispredict;
      res_valid_i && res_mispredict_i && cqv_q[res_tag_i] && !exc_take;
   endsequence
   sequence s_flushed;
      flush_o && iq_cnt_q == 4'h0 && !cqv_q[$past(res_tag_i) + 4'h1];
   endsequence
   property p_flush;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      s_mispredict |=> s_flushed;
   endproperty
   a_flush: assert property (p_flush) else $error("Mispredict did not discard younger");
   property p_unres;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      unres_cnt <= 5'(dcc_pkg::MAX_UNRES);
   endproperty
   a_unres: assert property (p_unres) else $error("Too many unresolved branches");
   property p_rename;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      rn_gen <= 5'(dcc_pkg::RN_DEPTH) && rn_flt <= 5'(dcc_pkg::RN_DEPTH)
         && inflight_o <= 5'(dcc_pkg::CQ_DEPTH);
   endproperty
   a_rename: assert property (p_rename) else $error("Rename or in-flight overflow");
endmodule

// ==== dcc_pkg.sv ====
package dcc_pkg;
   localparam int FETCH_W = 4;
   localparam int IQ_DEPTH = 12;
   localparam int DISP_W = 3;
   localparam int CQ_DEPTH = 16;
   localparam int TAG_W = 4;
   localparam int RET_W = 3;
   localparam int MAX_UNRES = 3;
   localparam int RN_DEPTH = 16;
   localparam int GEN_CAP = 3;
   localparam int FLT_CAP = 1;
   localparam int VEC_CAP = 2;
   localparam int BHT_DEPTH = 2048;
   localparam int BHT_IW = 11;
   localparam int BTC_SETS = 32;
   localparam int BTC_WAYS = 4;
   localparam int BTC_WORDS = 4;
   localparam int BTC_SW = 5;
   localparam int RAS_DEPTH = 8;
   localparam int RAS_PW = 3;
   localparam int PC_LSB = 2;
   localparam logic [31:0] PC_STEP = 32'h0000_0004;

   typedef enum logic [1:0] {U_NONE, U_GEN, U_FLT, U_VEC} unit_e;
   typedef enum logic [1:0] {BHT_SNT, BHT_WNT, BHT_WT, BHT_ST} bht_e;
   localparam bht_e BHT_RESET = BHT_WNT;

   typedef struct packed {
      logic [31:0] pc;
      logic [31:0] word;
      unit_e iq;
      unit_e rn;
      logic is_br;
      logic upd_cl;
      logic is_call;
      logic is_ret;
   } insn_s;

   typedef struct packed {
      logic [31:0] pc;
      unit_e rn;
      logic fin;
      logic exc;
      logic unres;
   } cq_s;
endpackage

// ==== branch_predict.sv ====
module branch_predict (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic look_valid_i,
   input wire logic [31:0] look_pc_i,
   input wire logic upd_valid_i,
   input wire logic [31:0] upd_pc_i,
   input wire logic upd_taken_i,
   input wire logic fill_valid_i,
   input wire logic [31:0] fill_pc_i,
   input wire logic [31:0] fill_target_i,
   input wire logic [dcc_pkg::BTC_WORDS-1:0][31:0] fill_words_i,
   input wire logic push_i,
   input wire logic [31:0] push_addr_i,
   input wire logic pop_i,
   output logic pred_taken_o,
   output logic btc_hit_o,
   output logic [31:0] btc_target_o,
   output logic [dcc_pkg::BTC_WORDS-1:0][31:0] btc_words_o,
   output logic [31:0] ras_top_o,
   output logic ras_valid_o
);
   localparam int TW = 32 - dcc_pkg::BTC_SW - dcc_pkg::PC_LSB;
   dcc_pkg::bht_e bht_q [dcc_pkg::BHT_DEPTH];
   logic [dcc_pkg::BTC_SETS-1:0][dcc_pkg::BTC_WAYS-1:0] bv_q;
   logic [TW-1:0] btag_q [dcc_pkg::BTC_SETS][dcc_pkg::BTC_WAYS];
   logic [31:0] btgt_q [dcc_pkg::BTC_SETS][dcc_pkg::BTC_WAYS];
   logic [dcc_pkg::BTC_WORDS-1:0][31:0] bwd_q [dcc_pkg::BTC_SETS][dcc_pkg::BTC_WAYS];
   logic [1:0] vict_q [dcc_pkg::BTC_SETS];
   logic [31:0] ras_q [dcc_pkg::RAS_DEPTH];
   logic [dcc_pkg::RAS_PW-1:0] sp_q;
   logic [dcc_pkg::RAS_PW:0] rcnt_q;
   logic [dcc_pkg::BHT_IW-1:0] ui;
   logic [dcc_pkg::BTC_SW-1:0] ls;
   logic [dcc_pkg::BTC_SW-1:0] fs;

   assign ui = upd_pc_i[dcc_pkg::PC_LSB +: dcc_pkg::BHT_IW];
   assign ls = look_pc_i[dcc_pkg::PC_LSB +: dcc_pkg::BTC_SW];
   assign fs = fill_pc_i[dcc_pkg::PC_LSB +: dcc_pkg::BTC_SW];

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < dcc_pkg::BHT_DEPTH; i++) begin
            bht_q[i] <= dcc_pkg::BHT_RESET;
         end
      end else if (upd_valid_i) begin
         if (upd_taken_i && bht_q[ui] != dcc_pkg::BHT_ST) begin
            bht_q[ui] <= dcc_pkg::bht_e'(bht_q[ui] + 2'h1);
         end else if (!upd_taken_i && bht_q[ui] != dcc_pkg::BHT_SNT) begin
            bht_q[ui] <= dcc_pkg::bht_e'(bht_q[ui] - 2'h1);
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bv_q <= '0;
         for (int s = 0; s < dcc_pkg::BTC_SETS; s++) begin
            vict_q[s] <= 2'h0;
         end
      end else if (fill_valid_i) begin
         bv_q[fs][vict_q[fs]] <= 1'b1;
         btag_q[fs][vict_q[fs]] <= fill_pc_i[31 -: TW];
         btgt_q[fs][vict_q[fs]] <= fill_target_i;
         bwd_q[fs][vict_q[fs]] <= fill_words_i;
         vict_q[fs] <= vict_q[fs] + 2'h1;
      end
   end

   // hit answered one cycle after lookup
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         btc_hit_o <= 1'b0;
         btc_target_o <= '0;
         btc_words_o <= '0;
         pred_taken_o <= 1'b0;
      end else begin
         btc_hit_o <= 1'b0;
         pred_taken_o <= look_valid_i &&
            bht_q[look_pc_i[dcc_pkg::PC_LSB +: dcc_pkg::BHT_IW]][1];
         for (int w = 0; w < dcc_pkg::BTC_WAYS; w++) begin
            if (look_valid_i && bv_q[ls][w] && btag_q[ls][w] == look_pc_i[31 -: TW]) begin
               btc_hit_o <= 1'b1;
               btc_target_o <= btgt_q[ls][w];
               btc_words_o <= bwd_q[ls][w];
            end
         end
      end
   end

   // return stack, oldest overwritten when deep
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sp_q <= '0;
         rcnt_q <= '0;
      end else if (push_i) begin
         ras_q[sp_q + 3'h1] <= push_addr_i;
         sp_q <= sp_q + 3'h1;
         if (rcnt_q != 4'(dcc_pkg::RAS_DEPTH)) begin
            rcnt_q <= rcnt_q + 4'h1;
         end
      end else if (pop_i && rcnt_q != 4'h0) begin
         sp_q <= sp_q - 3'h1;
         rcnt_q <= rcnt_q - 4'h1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ras_top_o <= '0;
         ras_valid_o <= 1'b0;
      end else begin
         ras_top_o <= ras_q[sp_q];
         ras_valid_o <= rcnt_q != 4'h0;
      end
   end

   property p_bht_sat;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      upd_valid_i && upd_taken_i && bht_q[ui] == dcc_pkg::BHT_ST |=> bht_q[$past(ui)] == dcc_pkg::BHT_ST;
   endproperty
   a_bht_sat: assert property (p_bht_sat) else $error("History counter left strong taken");
endmodule

// ==== exec_model.sv ====
module exec_model (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic hold_i,
   input wire logic [31:0] rnd_i,
   input wire logic [2:0] disp_valid_i,
   input wire logic [2:0][3:0] disp_tag_i,
   input wire logic flush_i,
   output logic [1:0] gen_room_o,
   output logic flt_room_o,
   output logic [1:0] vec_room_o,
   output logic fin_valid_o,
   output logic [3:0] fin_tag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] pend[$];
   int k;
   assign gen_room_o = hold_i ? 2'h3 : rnd_i[1:0];
   assign flt_room_o = hold_i | rnd_i[4];
   assign vec_room_o = (hold_i | rnd_i[3]) ? 2'h2 : {1'b0, rnd_i[2]};
   always @(posedge sys_clk_i or negedge arst_n_i) begin
      fin_valid_o <= 1'b0;
      if (!arst_n_i || flush_i) begin
         pend.delete();
      end else begin
         if (!hold_i && pend.size() != 0 && rnd_i[5]) begin
            k = rnd_i[13:8] % pend.size();
            fin_valid_o <= 1'b1;
            fin_tag_o <= pend[k];
            pend.delete(k);
         end
         for (int j = 0; j < 3; j++) begin
            if (disp_valid_i[j]) pend.push_back(disp_tag_i[j]);
         end
      end
   end
endmodule

// ==== dispatch_completion_control_bench.sv ====
module dispatch_completion_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic hold = 1'b0;
   logic rdy = 1'b0;
   logic res_v = 1'b0;
   logic look_v = 1'b0;
   logic fill_v = 1'b0;
   logic [3:0] fv = '0;
   logic [3:0] res_tag = '0;
   logic [31:0] rnd = 32'h0000_7bc1;
   logic [31:0] pc = 32'h0000_1000;
   logic [31:0] look_pc = '0;
   logic [31:0] fill_pc = '0;
   logic [3:0][31:0] fill_w = '0;
   dcc_pkg::insn_s [3:0] fi = '0;
   logic [1:0] gen_room, vec_room;
   logic flt_room, fin_v, fetch_ready, flush, pred_taken, btc_hit;
   logic [3:0] fin_tag;
   logic [2:0] disp_valid, ret_v;
   dcc_pkg::insn_s [2:0] disp_insn;
   logic [2:0][3:0] disp_tag;
   logic [2:0][31:0] ret_pc;
   logic [4:0] inflight;
   logic [31:0] btc_tg, ras_top;
   logic [3:0][31:0] btc_w;
   int err_count = 0;
   int n_checks = 0;
   int ndisp = 0;
   int nacc = 0;
   int nfl = 0;
   int d0, a0;
   logic ret_note = 1'b1;
   logic [31:0] exp_d[$];
   logic [31:0] exp_r[$];
   logic [3:0] btag[$];

   dispatch_completion_control i_dispatch_completion_control (
      .sys_clk_i, .arst_n_i, .fetch_valid_i(fv), .fetch_insn_i(fi),
      .gen_room_i(gen_room), .flt_room_i(flt_room), .vec_room_i(vec_room),
      .fin_valid_i(fin_v), .fin_tag_i(fin_tag), .fin_exc_i(1'b0),
      .res_valid_i(res_v), .res_tag_i(res_tag), .res_mispredict_i(res_v),
      .res_pc_i(32'h0000_2000), .res_taken_i(1'b1), .look_valid_i(look_v),
      .look_pc_i(look_pc), .btc_fill_valid_i(fill_v), .btc_fill_pc_i(fill_pc),
      .btc_fill_target_i(~fill_pc), .btc_fill_words_i(fill_w),
      .fetch_ready_o(fetch_ready), .disp_valid_o(disp_valid), .disp_insn_o(disp_insn),
      .disp_tag_o(disp_tag), .retire_valid_o(ret_v), .retire_pc_o(ret_pc),
      .exc_valid_o(), .exc_pc_o(), .flush_o(flush), .inflight_o(inflight),
      .pred_taken_o(pred_taken), .btc_hit_o(btc_hit), .btc_target_o(btc_tg),
      .btc_words_o(btc_w), .ras_top_o(ras_top), .ras_valid_o());
   exec_model i_exec_model (
      .sys_clk_i, .arst_n_i, .hold_i(hold), .rnd_i(rnd), .disp_valid_i(disp_valid),
      .disp_tag_i(disp_tag), .flush_i(flush), .gen_room_o(gen_room),
      .flt_room_o(flt_room), .vec_room_o(vec_room), .fin_valid_o(fin_v),
      .fin_tag_o(fin_tag));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Groups wait whole until accepted; the note is made at the taking edge
   task automatic send(input int n, input int kind, input int lim, input bit must);
      int t;
      logic [31:0] r;
      logic f;
      dcc_pkg::insn_s s;
      t = 0;
      while (n > 0 && t < lim) begin
         @(posedge sys_clk_i);
         t++;
         if (fv != 0 && rdy) begin
            for (int k = 0; k < 4; k++) begin
               f = fi[k].is_br && !fi[k].upd_cl;
               if (!f) exp_d.push_back(fi[k].pc);
               if (!f && ret_note) exp_r.push_back(fi[k].pc);
            end
            nacc += 4;
            n -= 4;
         end
         if (n > 0 && t < lim && (fv == 0 || rdy)) begin
            for (int k = 0; k < 4; k++) begin
               r = rnd >> (k * 6);
               s = '0;
               s.pc = pc;
               s.word = r;
               pc += dcc_pkg::PC_STEP;
               if (kind == 2) {s.is_br, s.upd_cl, s.is_call} = 3'h7;
               else if (kind == 1) s.iq = dcc_pkg::U_GEN;
               else begin
                  s.iq = dcc_pkg::unit_e'(r[1:0]);
                  s.rn = s.iq;
                  s.is_br = r[4:2] == 3'h0;
               end
               fi[k] <= s;
            end
            fv <= 4'hf;
         end else if (n <= 0 || t >= lim) fv <= '0;
      end
      if (must && n > 0) begin
         chk(n, 0);
         end_of_test();
      end
   endtask

   task automatic drain();
      int t;
      t = 0;
      while ((exp_r.size() != 0 || inflight != 0) && t < 2000) begin
         @(posedge sys_clk_i);
         t++;
      end
      if (t == 2000) begin
         chk(t, 0);
         end_of_test();
      end
   endtask

   task automatic look(input logic [31:0] a, input logic tk, input logic h);
      @(posedge sys_clk_i);
      look_v <= 1'b1;
      look_pc <= a;
      @(posedge sys_clk_i);
      look_v <= 1'b0;
      @(negedge sys_clk_i);
      chk(pred_taken, tk);
      chk(btc_hit, h);
   endtask

   initial forever #20 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) rnd <= xs(rnd);

   always @(negedge sys_clk_i) begin
      int nf, nv, ng;
      rdy = fetch_ready;
      nf = 0;
      nv = 0;
      ng = 0;
      if (arst_n_i) begin
         chk(disp_valid inside {3'h0, 3'h1, 3'h3, 3'h7}, 1'b1);
         for (int k = 0; k < 3; k++) begin
            if (disp_valid[k]) begin
               ndisp++;
               if (disp_insn[k].is_br) btag.push_back(disp_tag[k]);
               nf += disp_insn[k].iq == dcc_pkg::U_FLT;
               nv += disp_insn[k].iq == dcc_pkg::U_VEC;
               ng += disp_insn[k].iq == dcc_pkg::U_GEN;
               chk(disp_insn[k].pc, exp_d.size() ? exp_d.pop_front() : '1);
            end
            if (ret_v[k]) chk(ret_pc[k], exp_r.size() ? exp_r.pop_front() : '1);
         end
         chk(nf <= 1 && nv <= 2 && ng <= 3, 1'b1);
         chk(ret_v inside {3'h0, 3'h1, 3'h3, 3'h7}, 1'b1);
         chk(inflight <= 5'h10, 1'b1);
         nfl += flush;
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      look(32'h0000_2000, 1'b0, 1'b0);
      @(posedge sys_clk_i);
      fill_v <= 1'b1;
      fill_pc <= 32'h0000_3004;
      fill_w <= {rnd, ~rnd, xs(rnd), 32'h0000_3004};
      @(posedge sys_clk_i);
      fill_v <= 1'b0;
      look(32'h0000_3004, 1'b0, 1'b1);
      chk(btc_tg, ~32'h0000_3004);
      chk(btc_w[0], 32'h0000_3004);
      look(32'h0000_3084, 1'b0, 1'b0);
      send(48, 0, 800, 1);
      drain();
      // Retire queue held full, instruction queue then fills behind it
      hold <= 1'b1;
      d0 = ndisp;
      a0 = nacc;
      send(40, 1, 80, 0);
      chk(ndisp - d0, 16);
      chk(nacc - a0 inside {[25:28]}, 1'b1);
      chk(fetch_ready, 1'b0);
      chk(inflight, 5'h10);
      hold <= 1'b0;
      drain();
      hold <= 1'b1;
      ret_note = 1'b0;
      btag.delete();
      pc = 32'h0000_2000;
      d0 = ndisp;
      send(4, 2, 100, 1);
      repeat (20) @(posedge sys_clk_i);
      chk(ndisp - d0, 3);
      chk(exp_d.size(), 1);
      chk(ras_top, 32'h0000_2004);
      exp_d.delete();
      exp_r.push_back(32'h0000_2000);
      res_v <= 1'b1;
      res_tag <= btag[0];
      @(posedge sys_clk_i);
      res_v <= 1'b0;
      drain();
      chk(nfl, 1);
      hold <= 1'b0;
      look(32'h0000_2000, 1'b1, 1'b0);
      end_of_test();
   end
endmodule
